/* lcp_pkg.sv */
// Package with register map, field layout and timing constants for the LCD control block.
// How it works
// - Filter clock /128, then select /512../64.
// - Display disabled holds rails, backplanes, frontplanes and drive tick grounded.
// - Bias mode field picks drive scheme.
// - Segments assigned downward from segment 41.
// - Unclaimed shared pins stay general I/O.
// - Boost enable output follows bit 7.
// - Full-scale code goes to bias generator.
package lcp_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  // Printed offsets are not all multiples of four, so they are indices and byte address is four times each.
  localparam logic [15:0] LCP_IDX_BOOST_COUNT = 16'h2020;
  localparam logic [15:0] LCP_IDX_EN_MODE_CLK = 16'h2021;
  localparam logic [15:0] LCP_IDX_FULL_SCALE = 16'h2022;
  localparam int LCP_ADDR_W = 18;
  localparam logic [LCP_ADDR_W-1:0] LCP_ADR_BOOST_COUNT = {LCP_IDX_BOOST_COUNT, 2'h0};
  localparam logic [LCP_ADDR_W-1:0] LCP_ADR_EN_MODE_CLK = {LCP_IDX_EN_MODE_CLK, 2'h0};
  localparam logic [LCP_ADDR_W-1:0] LCP_ADR_FULL_SCALE = {LCP_IDX_FULL_SCALE, 2'h0};

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int LCP_BOOST_BIT = 7;
  localparam int LCP_COUNT_LSB = 0;
  localparam int LCP_COUNT_W = 5;
  localparam int LCP_CLK_LSB = 0;
  localparam int LCP_CLK_W = 2;
  localparam int LCP_MODE_LSB = 2;
  localparam int LCP_MODE_W = 3;
  localparam int LCP_EN_BIT = 5;
  localparam int LCP_FS_LSB = 0;
  localparam int LCP_FS_W = 5;
  localparam logic [7:0] LCP_RST_REG = 8'h00;
  localparam logic [4:0] LCP_COUNT_MAX = 5'h12;

  // ************************************************************
  // Shared pins: segments 24..41 pair with I/O 4..21
  // ************************************************************
  localparam int LCP_SHARED_N = 18;
  localparam int LCP_BACKPLANE_N = 4;
  localparam int LCP_FRONTPLANE_N = 42;
  localparam int LCP_FIRST_SHARED_FRONT = 24;

  // ************************************************************
  // Clock divider
  // ************************************************************
  localparam int LCP_BASE_DIV = 128;
  localparam int LCP_BASE_DIV_W = 7;
  localparam int LCP_SEL_DIV_W = 9;

  typedef enum logic [2:0] {
    LCP_M_4S_THIRD = 3'h0,
    LCP_M_3S_THIRD = 3'h1,
    LCP_M_2S_HALF = 3'h2,
    LCP_M_3S_HALF = 3'h3,
    LCP_M_STATIC = 3'h4
  } lcp_mode_t;

endpackage

/* lcp_clkdiv.sv */
// Divider that turns the filter clock into the selected pin drive clock.
`timescale 1ns/10ps
module lcp_clkdiv
  import lcp_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Control
  input wire logic i_run,
  input wire logic [LCP_CLK_W-1:0] i_sel,
  // Output
  output logic o_tick
);

  logic [LCP_BASE_DIV_W-1:0] base_cnt_ff;
  logic [LCP_SEL_DIV_W-1:0] sel_cnt_ff;
  logic tick_ff;
  wire base_tick = (base_cnt_ff == LCP_BASE_DIV_W'(LCP_BASE_DIV - 1));
  // Code 00 wraps at 2^9, 11 at 2^6; wrap when the low (9-sel) bits are all ones.
  wire [LCP_SEL_DIV_W-1:0] wrap_mask = LCP_SEL_DIV_W'((1 << (LCP_SEL_DIV_W - 32'(i_sel))) - 1);
  wire sel_wrap = base_tick && ((sel_cnt_ff & wrap_mask) == wrap_mask);

  // Two cascaded counters; a stopped divider restarts cleanly from zero.
  always_ff @(posedge i_clk) begin
    if (!i_rstn || !i_run) begin
      base_cnt_ff <= '0;
      sel_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      base_cnt_ff <= base_tick ? '0 : base_cnt_ff + 1'b1;
      if (base_tick) begin
        sel_cnt_ff <= sel_wrap ? '0 : sel_cnt_ff + 1'b1;
      end
      tick_ff <= sel_wrap;
    end
  end

  assign o_tick = tick_ff;

endmodule

/* lcp_top.sv */
// Top of the LCD control and pin share block with its Wishbone register slave.
`timescale 1ns/10ps
module lcp_top
  import lcp_pkg::*;
(
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [LCP_ADDR_W-1:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // Analog controls
  output logic O_BOOST_ENABLE,
  output logic O_BIAS_ENABLE,
  output logic [LCP_FS_W-1:0] O_FULL_SCALE_CODE,
  output logic [LCP_MODE_W-1:0] O_BIAS_MODE,
  // Glass drive
  output logic O_DRIVE_CLK_TICK,
  output logic [LCP_BACKPLANE_N-1:0] O_BACKPLANE_EN,
  output logic [LCP_FRONTPLANE_N-1:0] O_FRONTPLANE_EN,
  // Shared pin ownership
  output logic [LCP_SHARED_N-1:0] O_SHARED_IS_SEGMENT,
  output logic [LCP_SHARED_N-1:0] O_GENERAL_IO_EN
);

  // ************************************************************
  // Helper functions
  // ************************************************************
  // Merge of one written byte; all three control registers share it.
  function automatic logic [7:0] merge_byte(input logic take, input logic [7:0] din, input logic [7:0] old);
    logic [7:0] res;
    res = old;
    if (take) begin
      res = din;
    end
    return res;
  endfunction

  // Backplanes in use per mode: four, three, two, three or one.
  // Undefined codes take the static mask, so a stray write leaves the glass readable.
  function automatic logic [LCP_BACKPLANE_N-1:0] back_mask(input logic [LCP_MODE_W-1:0] mode);
    logic [LCP_BACKPLANE_N-1:0] mask;
    mask = 4'h1;
    unique case (mode)
      LCP_M_4S_THIRD: mask = 4'hF;
      LCP_M_3S_THIRD: mask = 4'h7;
      LCP_M_2S_HALF: mask = 4'h3;
      LCP_M_3S_HALF: mask = 4'h7;
      LCP_M_STATIC: mask = 4'h1;
      default: mask = 4'h1;
    endcase
    return mask;
  endfunction

  // Shared index k is segment 24+k and I/O 4+k; it is claimed when k >= 18 - N.
  // Claiming from the top keeps the low I/O numbers stable as the glass grows.
  function automatic logic [LCP_SHARED_N-1:0] claim_mask(input logic [LCP_COUNT_W-1:0] count);
    logic [LCP_SHARED_N-1:0] mask;
    mask = '0;
    for (int k = 0; k < LCP_SHARED_N; k++) begin
      mask[k] = (32'(k) >= 32'(LCP_SHARED_N) - 32'(count));
    end
    return mask;
  endfunction

  // ************************************************************
  // Register storage
  // ************************************************************
  logic [7:0] boost_count_ff;
  logic [7:0] en_mode_clk_ff;
  logic [7:0] full_scale_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;

  // Bus decode; a request is taken once and acked the next cycle.
  // Masking with ack keeps a held strobe from being taken a second time.
  wire req = I_WB_CYC && I_WB_STB && !ack_ff;
  wire hit_bc = (I_WB_ADR == LCP_ADR_BOOST_COUNT);
  wire hit_emc = (I_WB_ADR == LCP_ADR_EN_MODE_CLK);
  wire hit_fs = (I_WB_ADR == LCP_ADR_FULL_SCALE);
  wire wr_lane0 = req && I_WB_WE && I_WB_SEL[0];
  wire [7:0] wdat = I_WB_DAT[7:0];
  wire [7:0] nxt_boost_count = merge_byte(wr_lane0 && hit_bc, wdat, boost_count_ff);
  wire [7:0] nxt_en_mode_clk = merge_byte(wr_lane0 && hit_emc, wdat, en_mode_clk_ff);
  wire [7:0] nxt_full_scale = merge_byte(wr_lane0 && hit_fs, wdat, full_scale_ff);
  // Unmapped addresses still ack and read zero, so software never hangs.
  wire [7:0] rsel = hit_bc ? boost_count_ff : hit_emc ? en_mode_clk_ff : hit_fs ? full_scale_ff : 8'h00;
  // Read data is zero outside an answer, so a stale byte is never taken for a read.
  wire [31:0] nxt_rdat = (req && !I_WB_WE) ? {24'h000000, rsel} : 32'h00000000;

  // Control register writes; a write lands at the edge that takes the request.
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      boost_count_ff <= LCP_RST_REG;
      en_mode_clk_ff <= LCP_RST_REG;
      full_scale_ff <= LCP_RST_REG;
    end else begin
      boost_count_ff <= nxt_boost_count;
      en_mode_clk_ff <= nxt_en_mode_clk;
      full_scale_ff <= nxt_full_scale;
    end
  end

  // Bus answer: one ack pulse with the read byte beside it.
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else begin
      ack_ff <= req;
      rdat_ff <= nxt_rdat;
    end
  end

  // ************************************************************
  // Field extraction
  // ************************************************************
  wire boost_enable = boost_count_ff[LCP_BOOST_BIT];
  wire [LCP_COUNT_W-1:0] segment_pin_count = boost_count_ff[LCP_COUNT_LSB +: LCP_COUNT_W];
  wire [LCP_CLK_W-1:0] display_clock_select = en_mode_clk_ff[LCP_CLK_LSB +: LCP_CLK_W];
  wire [LCP_MODE_W-1:0] bias_mode = en_mode_clk_ff[LCP_MODE_LSB +: LCP_MODE_W];
  wire display_enable = en_mode_clk_ff[LCP_EN_BIT];
  wire [LCP_FS_W-1:0] full_scale_code = full_scale_ff[LCP_FS_LSB +: LCP_FS_W];

  // Codes above 18 are out of range; they are clamped so no phantom pin is claimed.
  // The register still reads back what was written, so software sees its own value.
  wire [LCP_COUNT_W-1:0] plane_count_eff = (segment_pin_count > LCP_COUNT_MAX) ? LCP_COUNT_MAX : segment_pin_count;

  // Undefined mode codes fall back to static drive.
  wire [LCP_MODE_W-1:0] mode_eff = (bias_mode > LCP_M_STATIC) ? LCP_M_STATIC : bias_mode;

  // Backplanes in use for the effective mode.
  wire [LCP_BACKPLANE_N-1:0] back_used = back_mask(mode_eff);

  // ************************************************************
  // Shared pin assignment
  // ************************************************************
  // Claim mask for the shared pins; it does not depend on the display enable.
  wire [LCP_SHARED_N-1:0] shared_is_plane = claim_mask(plane_count_eff);
  wire [LCP_SHARED_N-1:0] io_en = ~shared_is_plane;
  // The low frontplanes are dedicated and always belong to the glass.
  wire [LCP_FRONTPLANE_N-1:0] front_avail = {shared_is_plane, {LCP_FIRST_SHARED_FRONT{1'b1}}};

  // Disabled display grounds rails, backplanes and frontplanes.
  wire [LCP_BACKPLANE_N-1:0] nxt_back = display_enable ? back_used : '0;
  wire [LCP_FRONTPLANE_N-1:0] nxt_front = display_enable ? front_avail : '0;

  // ************************************************************
  // Drive clock
  // ************************************************************
  // The divider is held clear while dark, so the first tick comes a full period after enable.
  logic tick;
  lcp_clkdiv u_clkdiv (
    .i_clk(I_CORE_CLK),
    .i_rstn(I_RSTN),
    .i_run(display_enable),
    .i_sel(display_clock_select),
    .o_tick(tick)
  );

  // ************************************************************
  // Output stage
  // ************************************************************
  // Registered outputs; one cycle behind the control registers.
  // The extra stage keeps every pin glitch-free at the cost of one cycle of latency.
  logic boost_ff;
  logic bias_en_ff;
  logic [LCP_FS_W-1:0] fs_ff;
  logic [LCP_MODE_W-1:0] mode_ff;
  logic tick_ff;
  logic [LCP_BACKPLANE_N-1:0] back_ff;
  logic [LCP_FRONTPLANE_N-1:0] front_ff;
  logic [LCP_SHARED_N-1:0] shared_plane_ff;
  logic [LCP_SHARED_N-1:0] io_en_ff;

  // Analog controls and the drive tick.
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      boost_ff <= 1'b0;
      bias_en_ff <= 1'b0;
      fs_ff <= '0;
      mode_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      boost_ff <= boost_enable;
      bias_en_ff <= display_enable;
      fs_ff <= full_scale_code;
      mode_ff <= mode_eff;
      tick_ff <= tick;
    end
  end

  // Glass planes and shared pin ownership; pins come out of reset as general I/O.
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      back_ff <= '0;
      front_ff <= '0;
      shared_plane_ff <= '0;
      io_en_ff <= '1;
    end else begin
      back_ff <= nxt_back;
      front_ff <= nxt_front;
      shared_plane_ff <= shared_is_plane;
      io_en_ff <= io_en;
    end
  end

  // Every top output is a plain copy of a flip-flop.
  assign O_WB_DAT = rdat_ff;
  assign O_WB_ACK = ack_ff;
  assign O_BOOST_ENABLE = boost_ff;
  assign O_BIAS_ENABLE = bias_en_ff;
  assign O_FULL_SCALE_CODE = fs_ff;
  assign O_BIAS_MODE = mode_ff;
  assign O_DRIVE_CLK_TICK = tick_ff;
  assign O_BACKPLANE_EN = back_ff;
  assign O_FRONTPLANE_EN = front_ff;
  assign O_SHARED_IS_SEGMENT = shared_plane_ff;
  assign O_GENERAL_IO_EN = io_en_ff;

endmodule

/* lcp_props.sv */
// Checker with concurrent assertions for the LCD control block.
`timescale 1ns/10ps
module lcp_props
  import lcp_pkg::*;
(
  // Clock, reset and bus
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic [31:0] O_WB_DAT,
  input wire logic O_WB_ACK,
  // Glass and pins
  input wire logic O_BIAS_ENABLE,
  input wire logic [LCP_MODE_W-1:0] O_BIAS_MODE,
  input wire logic O_DRIVE_CLK_TICK,
  input wire logic [LCP_BACKPLANE_N-1:0] O_BACKPLANE_EN,
  input wire logic [LCP_FRONTPLANE_N-1:0] O_FRONTPLANE_EN,
  input wire logic [LCP_SHARED_N-1:0] O_SHARED_IS_SEGMENT,
  input wire logic [LCP_SHARED_N-1:0] O_GENERAL_IO_EN
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);
  // A taken request must be answered by a single ack pulse.
  sequence s_take;
    I_WB_CYC && I_WB_STB && !O_WB_ACK;
  endsequence
  sequence s_answer;
    O_WB_ACK ##1 !O_WB_ACK;
  endsequence
  a_ack_one_pulse: assert property (s_take |=> s_answer) else $error("ack not a single pulse");
  a_dat_idle_zero: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0) else $error("read data outside ack");
  a_dark_grounded: assert property (!O_BIAS_ENABLE |-> O_BACKPLANE_EN == 4'h0 && O_FRONTPLANE_EN == 42'h0)
    else $error("glass driven while disabled");
  a_dark_no_tick: assert property (!O_BIAS_ENABLE [*3] |-> !O_DRIVE_CLK_TICK)
    else $error("drive tick while disabled");
  a_mode_legal: assert property (O_BIAS_MODE <= 3'h4) else $error("undefined bias mode shown");
  a_static_plane: assert property ((O_BIAS_ENABLE && O_BIAS_MODE == 3'h4) [*2] |-> O_BACKPLANE_EN == 4'h1)
    else $error("static mode backplane wrong");
  a_io_split: assert property (O_GENERAL_IO_EN == ~O_SHARED_IS_SEGMENT) else $error("pin owned twice");
  a_top_first: assert property ((O_SHARED_IS_SEGMENT & ~(O_SHARED_IS_SEGMENT >> 1) & 18'h1FFFF) == 18'h0)
    else $error("segments not taken from the top");
  a_front_follow: assert property (($stable(O_SHARED_IS_SEGMENT) && O_BIAS_ENABLE) [*2] |->
    O_FRONTPLANE_EN == {O_SHARED_IS_SEGMENT, 24'hFFFFFF}) else $error("frontplane mismatch");
endmodule
bind lcp_top lcp_props chk_u (.I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_BIAS_ENABLE(O_BIAS_ENABLE),
  .O_BIAS_MODE(O_BIAS_MODE), .O_DRIVE_CLK_TICK(O_DRIVE_CLK_TICK), .O_BACKPLANE_EN(O_BACKPLANE_EN),
  .O_FRONTPLANE_EN(O_FRONTPLANE_EN), .O_SHARED_IS_SEGMENT(O_SHARED_IS_SEGMENT), .O_GENERAL_IO_EN(O_GENERAL_IO_EN));

/* lcp_glass_model.sv */
// Model of the glass that measures the pin drive clock period.
`timescale 1ns/10ps
module lcp_glass_model (
  // Clock and drive
  input wire logic i_clk,
  input wire logic i_tick,
  input wire logic i_bias_en,
  // Measurement
  output int o_period
);
  int cnt = 0;
  // A dark panel restarts the count, since its rails are grounded.
  // Rails coming up count as a start, so the first tick already gives a full period.
  always @(posedge i_clk) begin
    cnt <= i_tick ? 1 : (i_bias_en ? cnt + 1 : 0);
    if (i_tick) o_period <= cnt;
  end
endmodule

/* lcp_top_bench.sv */
// Self-checking bench for the LCD control block.
`timescale 1ns/10ps
module lcp_top_bench
  import lcp_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [LCP_ADDR_W-1:0] adr = '0;
  logic [31:0] wdat = '0, rdat;
  logic ack, boost, bias_en, tick;
  logic [4:0] fs;
  logic [2:0] mode;
  logic [3:0] bp;
  logic [41:0] front;
  logic [17:0] shared, io, ones = '1;
  logic [31:0] q;
  logic [3:0] sel = 4'hF;
  logic [3:0] bp_tab [8] = '{4'hF, 4'h7, 4'h3, 4'h7, 4'h1, 4'h1, 4'h1, 4'h1};
  int mismatches = 0, n_checks = 0, period, e;
  // ****
  // Clock, design and glass
  // ****
  always #2.5 clk = ~clk;
  lcp_top dut_u (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .O_BOOST_ENABLE(boost), .O_BIAS_ENABLE(bias_en), .O_FULL_SCALE_CODE(fs), .O_BIAS_MODE(mode),
    .O_DRIVE_CLK_TICK(tick), .O_BACKPLANE_EN(bp), .O_FRONTPLANE_EN(front),
    .O_SHARED_IS_SEGMENT(shared), .O_GENERAL_IO_EN(io));
  lcp_glass_model glass_u (.i_clk(clk), .i_tick(tick), .i_bias_en(bias_en), .o_period(period));
  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb(input logic w, input logic [LCP_ADDR_W-1:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
    n_checks++;
    if (ex !== got) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, ex, got);
    end
  endtask
  task automatic rd(input logic [LCP_ADDR_W-1:0] a, input logic [7:0] ex);
    wb(1'b0, a, 8'h00);
    chk("register", {24'h000000, ex}, q);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog sized well above the three divider runs.
  initial begin
    #450000;
    mismatches++;
    report_and_stop();
  end
  // ****
  // Test sequence
  // ****
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(LCP_ADR_BOOST_COUNT, 8'h00);
    rd(LCP_ADR_EN_MODE_CLK, 8'h00);
    rd(LCP_ADR_FULL_SCALE, 8'h00);
    chk("io", ones, io);
    wb(1'b1, 18'h0808C, 8'h5A);
    rd(18'h0808C, 8'h00);
    $display("test reset and map done");
    // Count 19 stands for an out-of-range 31, which the pins clamp to 18.
    for (int n = 0; n <= 19; n++) begin
      e = (n == 19) ? 18 : n;
      wb(1'b1, LCP_ADR_BOOST_COUNT, {n[0], 2'h0, (n == 19) ? 5'h1F : n[4:0]});
      chk("segments", 18'(~(ones >> e)), shared);
      chk("io", ones >> e, io);
      chk("boost", n[0], boost);
      rd(LCP_ADR_BOOST_COUNT, {n[0], 2'h0, (n == 19) ? 5'h1F : n[4:0]});
    end
    $display("test pin share done");
    wb(1'b1, LCP_ADR_FULL_SCALE, 8'h1F);
    chk("full scale", 5'h1F, fs);
    wb(1'b1, LCP_ADR_FULL_SCALE, 8'h0A);
    chk("full scale", 5'h0A, fs);
    // A write with lane 0 off is answered but leaves the register alone.
    sel <= 4'hE;
    wb(1'b1, LCP_ADR_FULL_SCALE, 8'h15);
    sel <= 4'hF;
    chk("lane 0 off", 5'h0A, fs);
    for (int m = 0; m < 8; m++) begin
      wb(1'b1, LCP_ADR_EN_MODE_CLK, {3'h1, m[2:0], 2'h3});
      chk("mode", (m > 4) ? 4 : m, mode);
      chk("backplane", bp_tab[m], bp);
      chk("frontplane", {42{1'b1}}, front);
      chk("bias enable", 1'b1, bias_en);
    end
    wb(1'b1, LCP_ADR_EN_MODE_CLK, 8'h00);
    chk("dark", 47'h0, {bias_en, bp, front});
    $display("test modes done");
    // Code 11 runs two periods to see the repeat; 10 and 01 only their first tick.
    for (int s = 3; s >= 1; s--) begin
      e = 128 << (9 - s);
      wb(1'b1, LCP_ADR_EN_MODE_CLK, {6'h08, s[1:0]});
      repeat ((s == 3) ? 2 * e + 8 : e + 8) @(posedge clk);
      chk("tick period", e, period);
      wb(1'b1, LCP_ADR_EN_MODE_CLK, 8'h00);
    end
    $display("test divider done");
    report_and_stop();
  end
endmodule
